// ---- common/zcd_pkg.sv ----
// Constants shared by the zero-cross detector control block.
// Assumes an 8-bit register port and a single peripheral clock.
package zcd_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ZCD_OFS_CTRL = 8'h00;
    localparam logic [7:0] ZCD_OFS_EDGE = 8'h02;
    localparam logic [7:0] ZCD_OFS_STATUS = 8'h03;
    localparam logic [7:0] ZCD_OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ZCD_OFS_IRQ_CLEAR = 8'h05;
    localparam logic [7:0] ZCD_OFS_IRQ_ENABLE = 8'h06;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ZCD_BIT_ENABLE = 0;
    localparam int ZCD_BIT_INVERT = 3;
    localparam int ZCD_BIT_ROUTE = 6;
    localparam int ZCD_BIT_RUNSLP = 7;
    localparam int ZCD_BIT_STATE = 4;
    localparam int ZCD_BIT_CROSS = 0;
    localparam int ZCD_IRQ_CROSS = 0;
    localparam int ZCD_IRQ_OVERRUN = 1;
    localparam int ZCD_IRQ_BITS = 2;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] ZCD_RST_CTRL = 8'h00;
    localparam logic [1:0] ZCD_RST_EDGE = 2'h0;
    localparam logic [1:0] ZCD_RST_IRQ = 2'h0;
    localparam logic [1:0] ZCD_EDGE_NONE = 2'h0;
    localparam logic [1:0] ZCD_EDGE_RISE = 2'h1;
    localparam logic [1:0] ZCD_EDGE_FALL = 2'h2;
    localparam logic [1:0] ZCD_EDGE_BOTH = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int ZCD_SYNC_STAGES = 3;

endpackage

// ---- design/zcd_sync.sv ----
// Multi-stage level synchroniser for an asynchronous input.
// Assumes the input may change at any time relative to the clock.
module zcd_sync
    import zcd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic async_i,
    output logic sync_o
);

    logic [ZCD_SYNC_STAGES-1:0] chain_ff;
    logic [ZCD_SYNC_STAGES-1:0] nxt_chain;

    // Shift the level along; only the next stage reads each flop
    always_comb begin
        nxt_chain = {chain_ff[ZCD_SYNC_STAGES-2:0], async_i};
    end

    // Plain shift register, cleared on reset
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= nxt_chain;
        end
    end

    assign sync_o = chain_ff[ZCD_SYNC_STAGES-1];

endmodule

// ---- design/zcd_ctrl.sv ----
// Register, interrupt and status logic of the zero-cross detector.
// Assumes an asynchronous comparator level, sleep levels from the
// power manager on sys_clk_i, and a one-cycle strobe register port.
//
// Strobed register access was decided locally.
module zcd_ctrl
    import zcd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic cmp_out_i,
    input wire logic sleep_standby_i,
    input wire logic sleep_powerdown_i,
    output logic pin_out_o,
    output logic pin_oe_n_o,
    output logic event_out_o,
    output logic cross_irq_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [1:0] edge_sel_ff;
    logic [1:0] nxt_edge_sel;
    logic cross_flag_ff;
    logic nxt_cross_flag;
    logic [ZCD_IRQ_BITS-1:0] irq_stat_ff;
    logic [ZCD_IRQ_BITS-1:0] nxt_irq_stat;
    logic [ZCD_IRQ_BITS-1:0] irq_en_ff;
    logic [ZCD_IRQ_BITS-1:0] nxt_irq_en;
    logic prev_out_ff;
    logic nxt_prev_out;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic cmp_sync;
    logic active;
    logic out_level;
    logic rise_seen;
    logic fall_seen;
    logic edge_hit;
    logic wr_ctrl;
    logic wr_edge;
    logic wr_status;
    logic wr_irq_clr;
    logic wr_irq_en;

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    assign wr_ctrl = reg_wr_i && (reg_addr_i == ZCD_OFS_CTRL);
    assign wr_edge = reg_wr_i && (reg_addr_i == ZCD_OFS_EDGE);
    assign wr_status = reg_wr_i && (reg_addr_i == ZCD_OFS_STATUS);
    assign wr_irq_clr = reg_wr_i && (reg_addr_i == ZCD_OFS_IRQ_CLEAR);
    assign wr_irq_en = reg_wr_i && (reg_addr_i == ZCD_OFS_IRQ_ENABLE);

    // ------------------------------------------------------------
    // Comparator input path
    // ------------------------------------------------------------
    // resynchronise comparator
    zcd_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .async_i(cmp_out_i),
        .sync_o(cmp_sync)
    );

    // Detector runs only when enabled and the sleep state allows it
    // enable gating
    assign active = ctrl_ff[ZCD_BIT_ENABLE] && !sleep_powerdown_i &&
                    (!sleep_standby_i || ctrl_ff[ZCD_BIT_RUNSLP]);

    // Synchronised output level; reads low while the detector is off
    // polarity inversion
    assign out_level = active && (cmp_sync ^ ctrl_ff[ZCD_BIT_INVERT]);

    // Edge detection on the synchronised level only, never the raw pin
    assign rise_seen = out_level && !prev_out_ff;
    assign fall_seen = !out_level && prev_out_ff;

    always_comb begin
        case (edge_sel_ff)
            ZCD_EDGE_NONE: edge_hit = 1'b0;
            ZCD_EDGE_RISE: edge_hit = rise_seen;
            ZCD_EDGE_FALL: edge_hit = fall_seen;
            ZCD_EDGE_BOTH: edge_hit = rise_seen || fall_seen;
            default: edge_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Pin and event outputs
    // ------------------------------------------------------------
    // The pin takes the synchronised level so no logic reads the raw
    // comparator; the cost is three cycles of latency on the pin.
    // pin routing
    assign pin_out_o = ctrl_ff[ZCD_BIT_ROUTE] &&
                       out_level;
    assign pin_oe_n_o = !(active && ctrl_ff[ZCD_BIT_ROUTE]);
    assign event_out_o = out_level;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Unused control bits are kept zero so they read back as zero
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_edge_sel = edge_sel_ff;
        nxt_irq_en = irq_en_ff;
        if (wr_ctrl) begin
            nxt_ctrl = 8'h00;
            nxt_ctrl[ZCD_BIT_ENABLE] = reg_wdata_i[ZCD_BIT_ENABLE];
            nxt_ctrl[ZCD_BIT_INVERT] = reg_wdata_i[ZCD_BIT_INVERT];
            nxt_ctrl[ZCD_BIT_ROUTE] = reg_wdata_i[ZCD_BIT_ROUTE];
            nxt_ctrl[ZCD_BIT_RUNSLP] = reg_wdata_i[ZCD_BIT_RUNSLP];
        end
        if (wr_edge) begin
            nxt_edge_sel = reg_wdata_i[1:0];
        end
        if (wr_irq_en) begin
            nxt_irq_en = reg_wdata_i[ZCD_IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl_ff <= ZCD_RST_CTRL;
            edge_sel_ff <= ZCD_RST_EDGE;
            irq_en_ff <= ZCD_RST_IRQ;
        end else begin
            ctrl_ff <= nxt_ctrl;
            edge_sel_ff <= nxt_edge_sel;
            irq_en_ff <= nxt_irq_en;
        end
    end

    // ------------------------------------------------------------
    // Crossing flag and interrupt status
    // ------------------------------------------------------------
    // A new edge in the clearing cycle wins, so no crossing is lost
    always_comb begin
        nxt_prev_out = out_level;
        nxt_cross_flag = cross_flag_ff;
        nxt_irq_stat = irq_stat_ff;
        if (wr_status && reg_wdata_i[ZCD_BIT_CROSS]) begin
            nxt_cross_flag = 1'b0;
        end
        if (edge_hit) begin
            nxt_cross_flag = 1'b1;
        end
        if (wr_irq_clr) begin
            nxt_irq_stat = irq_stat_ff & ~reg_wdata_i[ZCD_IRQ_BITS-1:0];
        end
        if (edge_hit) begin
            nxt_irq_stat[ZCD_IRQ_CROSS] = 1'b1;
        end
        if (edge_hit && cross_flag_ff) begin
            nxt_irq_stat[ZCD_IRQ_OVERRUN] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            prev_out_ff <= 1'b0;
            cross_flag_ff <= 1'b0;
            irq_stat_ff <= ZCD_RST_IRQ;
        end else begin
            prev_out_ff <= nxt_prev_out;
            cross_flag_ff <= nxt_cross_flag;
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    assign cross_irq_o = (edge_sel_ff != ZCD_EDGE_NONE) && cross_flag_ff;
    assign irq_o = |(irq_stat_ff & irq_en_ff);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Data valid only in the cycle after the read strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ZCD_OFS_CTRL: nxt_rdata = ctrl_ff;
                ZCD_OFS_EDGE: nxt_rdata = {6'h00, edge_sel_ff};
                ZCD_OFS_STATUS: begin
                    nxt_rdata[ZCD_BIT_STATE] = out_level;
                    nxt_rdata[ZCD_BIT_CROSS] = cross_flag_ff;
                end
                ZCD_OFS_IRQ_STATUS: nxt_rdata = {6'h00, irq_stat_ff};
                ZCD_OFS_IRQ_ENABLE: nxt_rdata = {6'h00, irq_en_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    // Configuration held steady over the synchroniser depth
    sequence cfg_steady_s;
        (active && $stable(ctrl_ff) && $stable(sleep_standby_i)
            && $stable(sleep_powerdown_i)) [*4];
    endsequence

    sequence status_read_s;
        reg_rd_i && (reg_addr_i == ZCD_OFS_STATUS);
    endsequence

    state_sync_a: assert property (
        cfg_steady_s |->
            out_level == ($past(cmp_out_i, 3) ^ ctrl_ff[ZCD_BIT_INVERT]))
        else $error("state bit not input delayed three cycles");

    flag_set_a: assert property (
        edge_hit |=> cross_flag_ff)
        else $error("selected edge did not set crossing flag");

    flag_clear_a: assert property (
        wr_status && reg_wdata_i[ZCD_BIT_CROSS] && !edge_hit
            |=> !cross_flag_ff)
        else $error("write of one did not clear crossing flag");

    zero_write_a: assert property (
        wr_status && !reg_wdata_i[ZCD_BIT_CROSS] && cross_flag_ff
            |=> cross_flag_ff)
        else $error("write of zero changed crossing flag");

    rise_only_a: assert property (
        edge_sel_ff == ZCD_EDGE_RISE && fall_seen && !cross_flag_ff
            && !wr_status |=> !cross_flag_ff)
        else $error("falling edge set flag in rising mode");

    irq_req_a: assert property (
        cross_flag_ff && edge_sel_ff != ZCD_EDGE_NONE && !wr_edge
            |-> cross_irq_o [*2] or (cross_irq_o ##1 !cross_flag_ff))
        else $error("interrupt request dropped while flag set");

    pin_route_a: assert property (
        !pin_oe_n_o |-> ctrl_ff[ZCD_BIT_ROUTE] && ctrl_ff[ZCD_BIT_ENABLE])
        else $error("pin driven without routing and enable");

    pin_sleep_a: assert property (
        sleep_powerdown_i |-> pin_oe_n_o && !event_out_o)
        else $error("detector alive in power-down");

    standby_off_a: assert property (
        (sleep_standby_i && !ctrl_ff[ZCD_BIT_RUNSLP]) [*2]
            |-> !edge_hit && pin_oe_n_o)
        else $error("detector alive in standby without keep-running");

    status_rd_a: assert property (
        status_read_s ##1 1'b1 |->
            reg_rdata_o[ZCD_BIT_CROSS] == $past(cross_flag_ff))
        else $error("status read did not return crossing flag");

endmodule

// ---- tb/zcd_cmp_model.sv ----
// Behavioural comparator that feeds the detector's raw level.
// Assumes the bench sets the wanted level; edges land off the clock.
module zcd_cmp_model (
    input wire logic level_i,
    input wire logic slow_i,
    output logic cmp_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Analogue settling delay, never aligned to the sampling edge
    initial begin
        cmp_o = 1'b0;
        forever begin
            @(level_i);
            cmp_o <= #(slow_i ? 9.7 : 1.3) level_i;
        end
    end
endmodule

// ---- tb/zero_cross_detector_ctrl_test.sv ----
// Self-checking bench for the zero-cross detector control block.
// Assumes one 250 MHz clock and a comparator model on the far side.
module zero_cross_detector_ctrl_test
    import zcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic cmp_lvl = 1'b0;
    logic cmp_slow = 1'b0;
    logic cmp_out;
    logic sleep_sb = 1'b0;
    logic sleep_pd = 1'b0;
    logic pin_out, pin_oe_n, event_out, cross_irq, irq;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] d;

    // ------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------
    always #2 sys_clk_i = ~sys_clk_i;

    zcd_cmp_model CMP (.level_i(cmp_lvl), .slow_i(cmp_slow),
        .cmp_o(cmp_out));

    zcd_ctrl DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cmp_out_i(cmp_out),
        .sleep_standby_i(sleep_sb), .sleep_powerdown_i(sleep_pd),
        .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n),
        .event_out_o(event_out), .cross_irq_o(cross_irq), .irq_o(irq));

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        v = reg_rdata_o;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a, d);
        chk8(d, exp);
    endtask

    // Fixed settle well beyond the three-flop synchroniser
    task automatic set_cmp(input logic v);
        @(posedge sys_clk_i);
        cmp_lvl <= v;
        repeat (8) @(posedge sys_clk_i);
    endtask

    task automatic clr_all();
        wr(ZCD_OFS_STATUS, 8'h01);
        wr(ZCD_OFS_IRQ_CLEAR, 8'h03);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rdchk(ZCD_OFS_CTRL, 8'h00);
        rdchk(ZCD_OFS_EDGE, 8'h00);
        rdchk(ZCD_OFS_STATUS, 8'h00);
        chk1(pin_oe_n, 1'b1);
        wr(ZCD_OFS_CTRL, 8'hff);
        rdchk(ZCD_OFS_CTRL, 8'hc9);
        wr(ZCD_OFS_EDGE, 8'hff);
        rdchk(ZCD_OFS_EDGE, 8'h03);
        wr(8'h01, 8'h5a);
        rdchk(8'h01, 8'h00);
        wr(ZCD_OFS_CTRL, 8'h01);
        clr_all();
    endtask

    // State bit and event level appear on the third edge
    task automatic t_sync();
        @(posedge sys_clk_i);
        cmp_lvl <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1 chk1(event_out, 1'b0);
        @(posedge sys_clk_i);
        #1 chk1(event_out, 1'b1);
        set_cmp(1'b0);
    endtask

    task automatic t_edges();
        for (int m = 0; m < 4; m++) begin
            wr(ZCD_OFS_EDGE, 8'(m));
            clr_all();
            set_cmp(1'b1);
            rdchk(ZCD_OFS_STATUS, {7'h08, m[0]});
            chk1(cross_irq, m[0]);
            clr_all();
            set_cmp(1'b0);
            rdchk(ZCD_OFS_STATUS, {7'h00, m[1]});
        end
    endtask

    task automatic t_w1c();
        wr(ZCD_OFS_EDGE, 8'h03);
        clr_all();
        cmp_slow <= 1'b1;
        set_cmp(1'b1);
        wr(ZCD_OFS_STATUS, 8'h00);
        rdchk(ZCD_OFS_STATUS, 8'h11);
        chk1(cross_irq, 1'b1);
        wr(ZCD_OFS_STATUS, 8'h01);
        rdchk(ZCD_OFS_STATUS, 8'h10);
        chk1(cross_irq, 1'b0);
        set_cmp(1'b0);
        cmp_slow <= 1'b0;
    endtask

    task automatic t_pin_sleep();
        wr(ZCD_OFS_CTRL, 8'h49);
        repeat (6) @(posedge sys_clk_i);
        chk1(pin_out, 1'b1);
        chk1(pin_oe_n, 1'b0);
        rdchk(ZCD_OFS_STATUS, 8'h11);
        wr(ZCD_OFS_CTRL, 8'h09);
        @(negedge sys_clk_i);
        chk1(pin_oe_n, 1'b1);
        wr(ZCD_OFS_CTRL, 8'h49);
        sleep_sb <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        chk1(pin_oe_n, 1'b1);
        rdchk(ZCD_OFS_STATUS, 8'h01);
        wr(ZCD_OFS_CTRL, 8'hc9);
        repeat (6) @(posedge sys_clk_i);
        chk1(pin_oe_n, 1'b0);
        rdchk(ZCD_OFS_STATUS, 8'h11);
        @(posedge sys_clk_i);
        sleep_sb <= 1'b0;
        sleep_pd <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        chk1(pin_oe_n, 1'b1);
        chk1(pin_out, 1'b0);
        sleep_pd <= 1'b0;
        wr(ZCD_OFS_CTRL, 8'h01);
        repeat (6) @(posedge sys_clk_i);
        clr_all();
    endtask

    // Sticky status, mask and write-one clear of the interrupt
    task automatic t_irq();
        wr(ZCD_OFS_EDGE, 8'h01);
        wr(ZCD_OFS_IRQ_ENABLE, 8'h01);
        clr_all();
        @(negedge sys_clk_i);
        chk1(irq, 1'b0);
        set_cmp(1'b1);
        chk1(irq, 1'b1);
        rdchk(ZCD_OFS_IRQ_STATUS, 8'h01);
        wr(ZCD_OFS_IRQ_ENABLE, 8'h00);
        @(negedge sys_clk_i);
        chk1(irq, 1'b0);
        wr(ZCD_OFS_IRQ_ENABLE, 8'h01);
        wr(ZCD_OFS_IRQ_CLEAR, 8'h01);
        @(negedge sys_clk_i);
        chk1(irq, 1'b0);
        rdchk(ZCD_OFS_IRQ_STATUS, 8'h00);
        // Second rise with the flag still set also marks an overrun
        set_cmp(1'b0);
        set_cmp(1'b1);
        rdchk(ZCD_OFS_IRQ_STATUS, 8'h03);
        set_cmp(1'b0);
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Whole run needs about 310 cycles; ceiling leaves margin
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_sync();
        t_edges();
        t_w1c();
        t_pin_sleep();
        t_irq();
        tally_and_finish();
    end
endmodule
